// ===== sim/hsi_ep_model.sv
// Behavioural interrupt endpoint answering the scheduler.
`timescale 1ns/1ps
module hsi_ep_model
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] delay,
    input wire logic [2:0] flags,
    input wire hsi_pkg::hsi_xact_req_t xact_req,
    output hsi_pkg::hsi_xact_rsp_t xact_rsp
);
    import hsi_pkg::*;
    logic [2:0] cnt;
    // Flags toggle outside the done pulse, so nobody may rely on them.
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            xact_rsp <= '0;
            cnt <= 3'h0;
        end
        else if (xact_req.valid && !xact_rsp.done && cnt == delay)
        begin
            xact_rsp <= {1'b1, flags};
            cnt <= 3'h0;
        end
        else
        begin
            xact_rsp <= {1'b0, ~xact_rsp[2:0]};
            if (xact_req.valid && !xact_rsp.done)
            begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule

// ===== sim/hsi_sched_monitor.sv
// Port checker for the microframe scheduler.
`timescale 1ns/1ps
module hsi_sched_monitor
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [4:0] bus_frame,
    input wire logic uframe_tick,
    input wire logic [2:0] uframe_index,
    input wire hsi_pkg::hsi_xact_req_t xact_req,
    input wire hsi_pkg::hsi_xact_rsp_t xact_rsp
);
    import hsi_pkg::*;
    // Shadow of the control word, so the issue checks see its settings.
    logic [17:8] ctl_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctl_r <= '0;
        else if (psel && penable && pready && pwrite && paddr == 8'h00)
            ctl_r <= pwdata[17:8];
    end
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    a_req_hold: assert property (xact_req.valid && !xact_rsp.done |=>
        $stable(xact_req)) else $error("request moved");
    a_req_drop: assert property (xact_req.valid && xact_rsp.done |=>
        !xact_req.valid) else $error("request stuck");
    a_issue_slot: assert property ($rose(xact_req.valid) |->
        $past(uframe_tick) && xact_req.uframe == $past(uframe_index))
        else $error("issue slot wrong");
    a_issue_cfg: assert property ($rose(xact_req.valid) |->
        xact_req.dir_in == $past(ctl_r[16]) && $past(ctl_r[17]))
        else $error("issue config wrong");
    a_frame_gate: assert property (uframe_tick && !xact_req.valid &&
        bus_frame != ctl_r[12:8] |=> !xact_req.valid)
        else $error("issue in wrong frame");
    c_issue: cover property ($rose(xact_req.valid));
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind hsi_uframe_sched hsi_sched_monitor u_mon (.ref_clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .bus_frame, .uframe_tick, .uframe_index,
    .xact_req, .xact_rsp);

// ===== sim/testbench.sv
// Self-checking bench for the microframe scheduler.
`timescale 1ns/1ps
module testbench;
    import hsi_pkg::*;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic uframe_tick;
    logic [7:0] paddr, act;
    logic [31:0] pwdata, prdata;
    logic [4:0] bus_frame, stat;
    logic [2:0] uframe_index, dly, flg, last;
    logic [2:0] res [8];
    hsi_xact_req_t xact_req;
    hsi_xact_rsp_t xact_rsp;
    logic [32:0] q [$];
    integer seed = 83396;
    int n_mismatch = 0;
    int samples_checked = 0;
    hsi_uframe_sched dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .bus_frame,
        .uframe_tick, .uframe_index, .xact_req, .xact_rsp);
    hsi_ep_model ep (.ref_clk, .sys_rst, .delay(dly), .flags(flg),
        .xact_req, .xact_rsp);
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [32:0] s, input logic [32:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Each transfer starts one edge after the last, never in the same step.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e);
        @(posedge ref_clk);
        q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge ref_clk)
        if (psel && penable && pready === 1'b1)
            check(pwrite ? {pslverr, 32'h0} : {pslverr, prdata},
                q.pop_front());
    task automatic tick(input logic [2:0] i);
        int k;
        @(posedge ref_clk);
        uframe_tick <= 1'b1;
        uframe_index <= i;
        @(posedge ref_clk);
        uframe_tick <= 1'b0;
        uframe_index <= 3'($random(seed));
        for (k = 0; k < 16 && (k < 3 || xact_req.valid); k++)
            @(posedge ref_clk);
    endtask
    task automatic round(input logic [7:0] m, input logic din,
        input logic [4:0] pf, input logic [4:0] bf);
        logic [2:0] r;
        act = act | m;
        bus_frame <= bf;
        apb(1'b1, 8'h00, {14'h0, 1'b1, din, 3'h0, pf, m}, 33'h0);
        apb(1'b0, 8'h00, 32'h0, {15'h0, 1'b1, din, 3'h0, pf, act});
        for (int i = 0; i < 8; i++)
        begin
            flg <= 3'($random(seed));
            dly <= 3'($random(seed));
            tick(i[2:0]);
            if (pf == bf && act[i])
            begin
                r = {flg[0] & ~din, flg[1] & din, flg[2]};
                res[i] = r;
                act[i] = 1'b0;
                last = i[2:0];
                stat = stat | {1'b0, r, 1'b1};
            end
        end
        apb(1'b0, 8'h04, 32'h0, {1'b0, res[7], res[6], res[5], res[4],
            res[3], res[2], res[1], res[0], act});
        apb(1'b0, 8'h10, 32'h0, {22'h0, last, 3'h0, bf});
    endtask
    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bus_frame = 5'h00;
        uframe_tick = 1'b0;
        uframe_index = 3'h0;
        dly = 3'h0;
        flg = 3'h0;
        act = 8'h00;
        stat = 5'h00;
        last = 3'h0;
        res = '{default: 3'h0};
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 24; a += 4)
            apb(1'b0, 8'(a), 32'h0, {a == 20, 32'h0});
        apb(1'b1, 8'h14, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(1'b1, 8'h0C, 32'h1F, 33'h0);
        round(8'h55, 1'b0, 5'h00, 5'h00);
        check({32'h0, irq}, 33'h1);
        apb(1'b0, 8'h08, 32'h0, {28'h0, stat});
        stat = 5'h00;
        repeat (2) @(posedge ref_clk);
        check({32'h0, irq}, 33'h0);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        round(8'hFF, 1'b1, 5'h05, 5'h03);
        round(8'h00, 1'b1, 5'h05, 5'h05);
        apb(1'b1, 8'h0C, 32'h0, 33'h0);
        round(8'h88, 1'b0, 5'h00, 5'h00);
        check({32'h0, irq}, 33'h0);
        // A second tick while the first request is still open is missed.
        flg <= 3'h0;
        dly <= 3'h7;
        apb(1'b1, 8'h00, 32'h0003_0001, 33'h0);
        uframe_tick <= 1'b1;
        uframe_index <= 3'h0;
        @(posedge ref_clk);
        uframe_tick <= 1'b0;
        @(posedge ref_clk);
        uframe_tick <= 1'b1;
        @(posedge ref_clk);
        uframe_tick <= 1'b0;
        repeat (14) @(posedge ref_clk);
        stat = stat | 5'h11;
        apb(1'b0, 8'h08, 32'h0, {28'h0, stat});
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule

// ===== src/hsi_pkg.sv
// Types shared by the microframe scheduler and its slots.
package hsi_pkg;

    typedef enum logic [1:0]
    {
        HSI_IDLE = 2'b00,
        HSI_BUSY = 2'b01
    } hsi_fsm_t;

    typedef struct packed
    {
        logic valid;
        logic [2:0] uframe;
        logic dir_in;
    } hsi_xact_req_t;

    typedef struct packed
    {
        logic done;
        logic err;
        logic babble;
        logic underrun;
    } hsi_xact_rsp_t;

    typedef struct packed
    {
        logic act;
        logic [2:0] result;
    } hsi_slot_t;

    typedef struct packed
    {
        hsi_fsm_t fsm;
        hsi_xact_req_t xreq;
        logic [4:0] poll_frame_number;
        logic dir_in;
        logic enable;
        logic [2:0] last_uf;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } hsi_state_t;

endpackage

// ===== src/hsi_regs.svh
// Register offsets, field positions and reset values of the scheduler.
//------------------------------------------------------------------------
// Summary of operation
// - Eight three-bit result fields, microframe seven on top.
// - Result field updated after its transaction completes.
// - Lowest result bit flags transaction error, both directions.
// - Middle result bit flags babble, inbound only.
// - Top result bit flags underrun, outbound only.
// - Software sets activation bits; hardware clears after use.
// - Activation bits checked only when frame numbers match.
// - Transaction issued in microframe n if bit set.
//------------------------------------------------------------------------
`ifndef HSI_REGS_SVH
`define HSI_REGS_SVH

`define HSI_ADDR_W 8
`define HSI_CTRL_OFS 8'h00
`define HSI_DESC_OFS 8'h04
`define HSI_IRQ_STAT_OFS 8'h08
`define HSI_IRQ_MASK_OFS 8'h0C
`define HSI_FRAME_OFS 8'h10

`define HSI_CTRL_ACT_LSB 0
`define HSI_CTRL_FRAME_LSB 8
`define HSI_CTRL_DIR_IN_BIT 16
`define HSI_CTRL_ENABLE_BIT 17

`define HSI_DESC_RESULT_LSB 8
`define HSI_FRAME_UF_LSB 8

`define HSI_EV_DONE 0
`define HSI_EV_ERR 1
`define HSI_EV_BABBLE 2
`define HSI_EV_UNDERRUN 3
`define HSI_EV_MISSED 4

`define HSI_RES_ERR_BIT 0
`define HSI_RES_BABBLE_BIT 1
`define HSI_RES_UNDERRUN_BIT 2

`define HSI_FRAME_RST 5'h00
`define HSI_IRQ_MASK_RST 5'h00
`define HSI_RESULT_RST 3'h0

`endif

// ===== src/hsi_uframe_sched.sv
// Microframe scheduler for high-speed interrupt transfers, APB slave.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "hsi_regs.svh"

module hsi_uframe_sched
#(
    parameter int NUM_UF = 8
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`HSI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [4:0] bus_frame,
    input wire logic uframe_tick,
    input wire logic [2:0] uframe_index,
    output hsi_pkg::hsi_xact_req_t xact_req,
    input wire hsi_pkg::hsi_xact_rsp_t xact_rsp
);
    import hsi_pkg::*;

    hsi_state_t st_r;
    hsi_state_t st_nxt;

    logic [NUM_UF-1:0] act_vec;
    logic [NUM_UF-1:0] arm_vec;
    logic [NUM_UF-1:0] retire_vec;
    logic [2:0] result_vec [NUM_UF];
    logic [2:0] outcome;
    logic [23:0] result_word;
    logic access;
    logic fire;
    logic wr_fire;
    logic rd_fire;
    logic mapped;
    logic frame_match;
    logic due;
    logic retiring;
    logic [4:0] events;
    logic [31:0] rd_word;
    logic missed;
    logic [4:0] stat_clr;

    //--------------------------------------------------------------------
    // Slots
    //--------------------------------------------------------------------
    for (genvar i = 0; i < NUM_UF; i++)
    begin : g_slot
        hsi_uframe_slot u_slot
        (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .arm(arm_vec[i]),
            .retire(retire_vec[i]),
            .outcome(outcome),
            .act(act_vec[i]),
            .result(result_vec[i])
        );
    end

    //--------------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------------
    always_comb
    begin
        access = psel && penable;
        fire = access && st_r.pready;
        wr_fire = fire && pwrite && !st_r.pslverr;
        rd_fire = fire && !pwrite && !st_r.pslverr;
        // Offsets must match exactly; any other address is refused.
        case (paddr)
            `HSI_CTRL_OFS,
            `HSI_DESC_OFS,
            `HSI_IRQ_STAT_OFS,
            `HSI_IRQ_MASK_OFS,
            `HSI_FRAME_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    //--------------------------------------------------------------------
    // Outcome of the finished transaction
    //--------------------------------------------------------------------
    always_comb
    begin
        outcome = `HSI_RESULT_RST;
        outcome[`HSI_RES_ERR_BIT] = xact_rsp.err;
        outcome[`HSI_RES_BABBLE_BIT] =
            xact_rsp.babble && st_r.xreq.dir_in;
        outcome[`HSI_RES_UNDERRUN_BIT] =
            xact_rsp.underrun && !st_r.xreq.dir_in;
        retiring = (st_r.fsm == HSI_BUSY) && xact_rsp.done;
        for (int i = 0; i < NUM_UF; i++)
        begin
            retire_vec[i] = retiring &&
                (st_r.xreq.uframe == 3'(i));
            arm_vec[i] = wr_fire && (paddr == `HSI_CTRL_OFS) &&
                pwdata[`HSI_CTRL_ACT_LSB + i];
        end
    end

    //--------------------------------------------------------------------
    // Schedule check
    //--------------------------------------------------------------------
    always_comb
    begin
        // Only the low five frame bits are compared, so a polling period
        // longer than thirty-two frames aliases onto an earlier frame.
        frame_match = (st_r.poll_frame_number == bus_frame);
        due = uframe_tick && st_r.enable && frame_match &&
            act_vec[uframe_index];
    end

    //--------------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------------
    always_comb
    begin
        result_word = '0;
        for (int i = 0; i < NUM_UF; i++)
        begin
            result_word[3*i +: 3] = result_vec[i];
        end
        rd_word = '0;
        case (paddr)
            `HSI_CTRL_OFS:
            begin
                rd_word[`HSI_CTRL_ACT_LSB +: 8] = act_vec;
                rd_word[`HSI_CTRL_FRAME_LSB +: 5] = st_r.poll_frame_number;
                rd_word[`HSI_CTRL_DIR_IN_BIT] = st_r.dir_in;
                rd_word[`HSI_CTRL_ENABLE_BIT] = st_r.enable;
            end
            `HSI_DESC_OFS:
            begin
                rd_word[`HSI_DESC_RESULT_LSB +: 24] = result_word;
                rd_word[7:0] = act_vec;
            end
            `HSI_IRQ_STAT_OFS:
            begin
                rd_word[4:0] = st_r.irq_stat;
            end
            `HSI_IRQ_MASK_OFS:
            begin
                rd_word[4:0] = st_r.irq_mask;
            end
            `HSI_FRAME_OFS:
            begin
                rd_word[4:0] = bus_frame;
                rd_word[`HSI_FRAME_UF_LSB +: 3] = st_r.last_uf;
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
    end

    //--------------------------------------------------------------------
    // Interrupt events
    //--------------------------------------------------------------------
    always_comb
    begin
        missed = (st_r.fsm == HSI_BUSY) && uframe_tick && !xact_rsp.done;
        events = 5'h00;
        events[`HSI_EV_DONE] = retiring;
        events[`HSI_EV_ERR] = retiring && outcome[`HSI_RES_ERR_BIT];
        events[`HSI_EV_BABBLE] =
            retiring && outcome[`HSI_RES_BABBLE_BIT];
        events[`HSI_EV_UNDERRUN] =
            retiring && outcome[`HSI_RES_UNDERRUN_BIT];
        events[`HSI_EV_MISSED] = missed;
        // Only the bits that the read reported are cleared, so an event
        // landing after the data was latched is kept for the next read.
        stat_clr = 5'h00;
        if (rd_fire && (paddr == `HSI_IRQ_STAT_OFS))
        begin
            stat_clr = st_r.prdata[4:0];
        end
    end

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        //----------------------------------------------------------------
        // Bus response
        //----------------------------------------------------------------
        // One wait state: pready is registered high at the end of the first
        // access cycle and the transfer completes on the edge after the second.
        if (fire)
        begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
        else if (access)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !mapped;
            st_nxt.prdata = mapped ? rd_word : 32'h0000_0000;
        end

        //----------------------------------------------------------------
        // Configuration writes
        //----------------------------------------------------------------
        if (wr_fire && (paddr == `HSI_CTRL_OFS))
        begin
            st_nxt.poll_frame_number = pwdata[`HSI_CTRL_FRAME_LSB +: 5];
            st_nxt.dir_in = pwdata[`HSI_CTRL_DIR_IN_BIT];
            st_nxt.enable = pwdata[`HSI_CTRL_ENABLE_BIT];
        end
        if (wr_fire && (paddr == `HSI_IRQ_MASK_OFS))
        begin
            st_nxt.irq_mask = pwdata[4:0];
        end

        //----------------------------------------------------------------
        // Transaction sequencer
        //----------------------------------------------------------------
        // A tick that meets a busy sequencer is dropped, not queued: the
        // endpoint sees at most one request, and unless done arrives in the same
        // cycle the missed event tells software that its schedule was too tight.
        case (st_r.fsm)
            HSI_IDLE:
            begin
                if (due)
                begin
                    st_nxt.fsm = HSI_BUSY;
                    st_nxt.xreq.valid = 1'b1;
                    st_nxt.xreq.uframe = uframe_index;
                    st_nxt.xreq.dir_in = st_r.dir_in;
                end
            end
            HSI_BUSY:
            begin
                if (xact_rsp.done)
                begin
                    st_nxt.fsm = HSI_IDLE;
                    st_nxt.xreq.valid = 1'b0;
                    st_nxt.last_uf = st_r.xreq.uframe;
                end
            end
            default:
            begin
                st_nxt.fsm = HSI_IDLE;
                st_nxt.xreq.valid = 1'b0;
            end
        endcase

        //----------------------------------------------------------------
        // Interrupt status
        //----------------------------------------------------------------
        // Set wins over clear: an event in the clearing cycle survives.
        st_nxt.irq_stat = (st_r.irq_stat & ~stat_clr) | events;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '{
                fsm: HSI_IDLE,
                xreq: '{valid: 1'b0, uframe: 3'h0, dir_in: 1'b0},
                poll_frame_number: `HSI_FRAME_RST,
                dir_in: 1'b0,
                enable: 1'b0,
                last_uf: 3'h0,
                irq_stat: 5'h00,
                irq_mask: `HSI_IRQ_MASK_RST,
                irq: 1'b0,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h0000_0000
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    // Every output is a register bit, so no decode glitch reaches a pin.
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq = st_r.irq;
    assign xact_req = st_r.xreq;
endmodule

// ===== src/hsi_uframe_slot.sv
// One microframe slot: activation bit and three-bit result field.
`timescale 1ns/1ps
`include "hsi_regs.svh"

module hsi_uframe_slot
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic arm,
    input wire logic retire,
    input wire logic [2:0] outcome,
    output logic act,
    output logic [2:0] result
);
    import hsi_pkg::*;

    hsi_slot_t st_r;
    hsi_slot_t st_nxt;

    //--------------------------------------------------------------------
    // Slot state
    //--------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        if (retire)
        begin
            st_nxt.act = 1'b0;
            st_nxt.result = outcome;
        end
        // A fresh request from software outranks the retire in the
        // same cycle, so a new arm is never swallowed.
        if (arm)
        begin
            st_nxt.act = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_r <= '{act: 1'b0, result: `HSI_RESULT_RST};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign act = st_r.act;
    assign result = st_r.result;
endmodule
